// [design/synth_cfg_regs.vh]
`ifndef SYNTH_CFG_REGS_VH
`define SYNTH_CFG_REGS_VH

// ----------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define IDX_CONTROL        6'h00
`define IDX_PUMP_GAIN_UP   6'h29
`define IDX_EXT_PUMP       6'h2a
`define IDX_CAL_START      6'h2e
`define IDX_DITHER         6'h2f
`define IDX_FIXED_A        6'h35
`define IDX_FIXED_B        6'h3a
`define IDX_STATUS         6'h3e

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define RST_PUMP_GAIN_UP   16'h0810
`define RST_EXT_PUMP       16'h0210
`define RST_CAL_START      16'h001a
`define RST_DITHER         16'h0000
`define RST_FIXED_A        16'h2802
`define RST_FIXED_B        16'h0c00

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CTRL_SOFT_RESET    13
`define DITHER_MSB         14
`define DITHER_LSB         13
`define CAL_FORCE_BIT      2
`define CAL_CORE_MSB       1
`define CAL_CORE_LSB       0
`define EXT_POL_BIT        5
`define EXT_DOWN_MSB       4
`define EXT_DOWN_LSB       0
`define UP_CUR_MSB         11
`define UP_CUR_LSB         7

// ----------------------------------------------------------------
// Core codes and bus responses
// ----------------------------------------------------------------
`define CORE_LOW           2'h0
`define CORE_MID           2'h1
`define CORE_HIGH          2'h2
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// [design/cfg_word_reg.v]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// One 16-bit read/write configuration word
// ----------------------------------------------------------------
module cfg_word_reg #(
  parameter [15:0] RESET_VAL = 16'h0000
) (
  input  wire        i_clk_sys,  // System clock
  input  wire        i_load,     // Load reset value
  input  wire        i_wr,       // Write strobe
  input  wire [1:0]  i_be,       // Byte enables
  input  wire [15:0] i_wdata,    // Write data
  output reg  [15:0] o_q         // Stored word
);

  // Reload beats a write so a soft reset always wins
  always @(posedge i_clk_sys) begin
    if (i_load) begin
      o_q <= RESET_VAL;
    end else if (i_wr) begin
      if (i_be[0]) begin
        o_q[7:0] <= i_wdata[7:0];
      end
      if (i_be[1]) begin
        o_q[15:8] <= i_wdata[15:8];
      end
    end
  end

endmodule

// [design/dither_source.v]
`timescale 1ns/1ps

// ----------------------------------------------------------------
// Pseudo-random dither for the modulator sequence
// ----------------------------------------------------------------
module dither_source #(
  parameter [15:0] SEED = 16'hace1
) (
  input  wire       i_clk_sys,  // System clock
  input  wire       i_rst,      // Sync reset, active high
  input  wire [1:0] i_level,    // Dither level code
  output reg  [2:0] o_noise     // Noise word added to sequence
);

  reg  [15:0] lfsr;
  reg  [2:0]  mask;

  // Stronger level opens more random bits
  always @* begin
    case (i_level)
      2'h1:    mask = 3'h1;
      2'h2:    mask = 3'h3;
      2'h3:    mask = 3'h7;
      default: mask = 3'h0;
    endcase
  end

  // Maximal length taps, never locks up at zero
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      lfsr    <= SEED;
      o_noise <= 3'h0;
    end else begin
      lfsr    <= {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
      o_noise <= lfsr[2:0] & mask;
    end
  end

endmodule

// [design/synth_config_register_slice.v]
// Our own choice: the AXI4-Lite slave port.
`timescale 1ns/1ps
`include "synth_cfg_regs.vh"

module synth_config_register_slice #(
  parameter ADDR_W = 8
) (
  input  wire              i_clk_sys,        // 100 MHz system clock
  input  wire              i_rst,            // Sync reset, active high
  // AXI4-Lite write address
  input  wire [ADDR_W-1:0] i_awaddr,         // Write address
  input  wire [2:0]        i_awprot,         // Unused protection
  input  wire              i_awvalid,        // Write address valid
  output reg               o_awready,        // Write address ready
  // AXI4-Lite write data
  input  wire [31:0]       i_wdata,          // Write data
  input  wire [3:0]        i_wstrb,          // Byte strobes
  input  wire              i_wvalid,         // Write data valid
  output reg               o_wready,         // Write data ready
  // AXI4-Lite write response
  output reg  [1:0]        o_bresp,          // Write response
  output reg               o_bvalid,         // Response valid
  input  wire              i_bready,         // Response ready
  // AXI4-Lite read address
  input  wire [ADDR_W-1:0] i_araddr,         // Read address
  input  wire [2:0]        i_arprot,         // Unused protection
  input  wire              i_arvalid,        // Read address valid
  output reg               o_arready,        // Read address ready
  // AXI4-Lite read data
  output reg  [31:0]       o_rdata,          // Read data
  output reg  [1:0]        o_rresp,          // Read response
  output reg               o_rvalid,         // Read data valid
  input  wire              i_rready,         // Read data ready
  // Calibration and modulator side
  input  wire [1:0]        i_auto_core,      // Core chosen by calibration
  output reg               o_cal_start_force,  // Start core forced
  output reg  [1:0]        o_cal_start_core,   // Effective start core
  output reg               o_low_band_core,    // Start on low band
  output reg               o_mid_band_core,    // Start on mid band
  output reg               o_high_band_core,   // Start on high band
  output reg  [1:0]        o_dither_level,     // Dither level code
  output reg  [2:0]        o_dither_noise,     // Modulator dither word
  output reg               o_ext_pump_polarity, // 1 = negative
  output reg  [4:0]        o_ext_pump_down,    // Down current code
  output reg  [4:0]        o_ext_pump_up,      // Up current code
  output reg  [5:0]        o_ext_pump_total,   // Down plus up code
  output reg               o_ext_pump_tristate, // Down pump off
  output reg  [15:0]       o_pump_gain_up,     // Word at 0x29
  output reg  [15:0]       o_fixed_a,          // Word at 0x35
  output reg  [15:0]       o_fixed_b           // Word at 0x3a
);

  // ----------------------------------------------------------------
  // Bus holding state
  // ----------------------------------------------------------------
  reg               aw_full;
  reg               w_full;
  reg  [5:0]        aw_idx;
  reg  [15:0]       w_data;
  reg  [1:0]        w_be;

  wire              wr_fire;
  wire              wr_hit;
  wire              soft_rst;
  wire              load_all;
  wire [5:0]        ar_idx;

  // Stored words
  wire [15:0]       word_pump;
  wire [15:0]       word_ext;
  wire [15:0]       word_cal;
  wire [15:0]       word_dith;
  wire [15:0]       word_fa;
  wire [15:0]       word_fb;

  // Per-word write strobes
  wire              wr_pump;
  wire              wr_ext;
  wire              wr_cal;
  wire              wr_dith;
  wire              wr_fa;
  wire              wr_fb;

  wire [2:0]        noise;
  reg  [1:0]        next_core;
  reg  [31:0]       next_rdata;
  reg               next_rhit;
  wire [15:0]       status_word;

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------

  // Write happens once both halves are held and no response pends
  assign wr_fire  = aw_full & w_full & ~o_bvalid;

  assign wr_pump  = wr_fire & (aw_idx == `IDX_PUMP_GAIN_UP);
  assign wr_ext   = wr_fire & (aw_idx == `IDX_EXT_PUMP);
  assign wr_cal   = wr_fire & (aw_idx == `IDX_CAL_START);
  assign wr_dith  = wr_fire & (aw_idx == `IDX_DITHER);
  assign wr_fa    = wr_fire & (aw_idx == `IDX_FIXED_A);
  assign wr_fb    = wr_fire & (aw_idx == `IDX_FIXED_B);

  // Status is read-only, so a write to it is refused
  assign wr_hit   = wr_pump | wr_ext | wr_cal | wr_dith | wr_fa | wr_fb
                  | (wr_fire & (aw_idx == `IDX_CONTROL));

  assign soft_rst = wr_fire & (aw_idx == `IDX_CONTROL) & w_be[1]
                  & w_data[`CTRL_SOFT_RESET];

  assign load_all = i_rst | soft_rst;

  // ----------------------------------------------------------------
  // Write channel handshakes
  // ----------------------------------------------------------------

  // Address and data are taken in either order, one write at a time
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_awready <= 1'b1;
      o_wready  <= 1'b1;
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      aw_idx    <= 6'h00;
      w_data    <= 16'h0000;
      w_be      <= 2'h0;
      o_bvalid  <= 1'b0;
      o_bresp   <= `RESP_OKAY;
    end else begin
      if (i_awvalid & o_awready) begin
        o_awready <= 1'b0;
        aw_full   <= 1'b1;
        aw_idx    <= i_awaddr[7:2];
      end
      if (i_wvalid & o_wready) begin
        o_wready <= 1'b0;
        w_full   <= 1'b1;
        w_data   <= i_wdata[15:0];
        w_be     <= i_wstrb[1:0];
      end
      if (wr_fire) begin
        o_bvalid <= 1'b1;
        o_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
        aw_full  <= 1'b0;
        w_full   <= 1'b0;
      end
      // Ready rises only after the response has gone
      if (o_bvalid & i_bready) begin
        o_bvalid  <= 1'b0;
        o_awready <= 1'b1;
        o_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Register words
  // ----------------------------------------------------------------

  cfg_word_reg #(.RESET_VAL(`RST_PUMP_GAIN_UP)) u_pump (
    .i_clk_sys (i_clk_sys),
    .i_load    (load_all),
    .i_wr      (wr_pump),
    .i_be      (w_be),
    .i_wdata   (w_data),
    .o_q       (word_pump)
  );

  // reserved upper bits kept as written
  cfg_word_reg #(.RESET_VAL(`RST_EXT_PUMP)) u_ext (
    .i_clk_sys (i_clk_sys),
    .i_load    (load_all),
    .i_wr      (wr_ext),
    .i_be      (w_be),
    .i_wdata   (w_data),
    .o_q       (word_ext)
  );

  // reserved upper bits kept as written
  cfg_word_reg #(.RESET_VAL(`RST_CAL_START)) u_cal (
    .i_clk_sys (i_clk_sys),
    .i_load    (load_all),
    .i_wr      (wr_cal),
    .i_be      (w_be),
    .i_wdata   (w_data),
    .o_q       (word_cal)
  );

  cfg_word_reg #(.RESET_VAL(`RST_DITHER)) u_dith (
    .i_clk_sys (i_clk_sys),
    .i_load    (load_all),
    .i_wr      (wr_dith),
    .i_be      (w_be),
    .i_wdata   (w_data),
    .o_q       (word_dith)
  );

  cfg_word_reg #(.RESET_VAL(`RST_FIXED_A)) u_fa (
    .i_clk_sys (i_clk_sys),
    .i_load    (load_all),
    .i_wr      (wr_fa),
    .i_be      (w_be),
    .i_wdata   (w_data),
    .o_q       (word_fa)
  );

  cfg_word_reg #(.RESET_VAL(`RST_FIXED_B)) u_fb (
    .i_clk_sys (i_clk_sys),
    .i_load    (load_all),
    .i_wr      (wr_fb),
    .i_be      (w_be),
    .i_wdata   (w_data),
    .o_q       (word_fb)
  );

  // ----------------------------------------------------------------
  // Modulator dither
  // ----------------------------------------------------------------

  dither_source u_dither (
    .i_clk_sys (i_clk_sys),
    .i_rst     (load_all),
    .i_level   (word_dith[`DITHER_MSB:`DITHER_LSB]),
    .o_noise   (noise)
  );

  // ----------------------------------------------------------------
  // Calibration start core
  // ----------------------------------------------------------------

  always @* begin
    if (word_cal[`CAL_FORCE_BIT]) begin
      next_core = word_cal[`CAL_CORE_MSB:`CAL_CORE_LSB];
    end else begin
      next_core = i_auto_core;
    end
  end

  // ----------------------------------------------------------------
  // Decoded outputs
  // ----------------------------------------------------------------

  // All functional outputs are registered, one cycle after the word; dither noise lags its level by one, the word by two
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_cal_start_force   <= 1'b0;
      o_cal_start_core    <= `CORE_HIGH;
      o_low_band_core     <= 1'b0;
      o_mid_band_core     <= 1'b0;
      o_high_band_core    <= 1'b0;
      o_dither_level      <= 2'h0;
      o_dither_noise      <= 3'h0;
      o_ext_pump_polarity <= 1'b0;
      o_ext_pump_down     <= 5'h00;
      o_ext_pump_up       <= 5'h00;
      o_ext_pump_total    <= 6'h00;
      o_ext_pump_tristate <= 1'b1;
      o_pump_gain_up      <= `RST_PUMP_GAIN_UP;
      o_fixed_a           <= `RST_FIXED_A;
      o_fixed_b           <= `RST_FIXED_B;
    end else begin
      o_cal_start_force <= word_cal[`CAL_FORCE_BIT];
      o_cal_start_core  <= next_core;
      // core decode, code 3 selects none
      o_low_band_core   <= (next_core == `CORE_LOW);
      o_mid_band_core   <= (next_core == `CORE_MID);
      o_high_band_core  <= (next_core == `CORE_HIGH);
      o_dither_level    <= word_dith[`DITHER_MSB:`DITHER_LSB];
      o_dither_noise    <= noise;
      o_ext_pump_polarity <= word_ext[`EXT_POL_BIT];
      o_ext_pump_down     <= word_ext[`EXT_DOWN_MSB:`EXT_DOWN_LSB];
      o_ext_pump_tristate <= (word_ext[`EXT_DOWN_MSB:`EXT_DOWN_LSB] == 5'h00);
      o_ext_pump_up       <= word_pump[`UP_CUR_MSB:`UP_CUR_LSB];
      o_ext_pump_total    <= {1'b0, word_ext[`EXT_DOWN_MSB:`EXT_DOWN_LSB]}
                           + {1'b0, word_pump[`UP_CUR_MSB:`UP_CUR_LSB]};
      o_pump_gain_up      <= word_pump;
      o_fixed_a           <= word_fa;
      o_fixed_b           <= word_fb;
    end
  end

  // odd or unequal codes pass through unchecked

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------

  // Live state for software: effective core, dither level, pump total and tristate flag
  assign status_word = {5'h00, o_ext_pump_tristate, o_ext_pump_total,
                        o_dither_level, o_cal_start_core};

  assign ar_idx = i_araddr[7:2];

  always @* begin
    next_rdata = 32'h0000_0000;
    next_rhit  = 1'b1;
    case (ar_idx)
      `IDX_CONTROL:      next_rdata = 32'h0000_0000;
      `IDX_PUMP_GAIN_UP: next_rdata = {16'h0000, word_pump};
      `IDX_EXT_PUMP:     next_rdata = {16'h0000, word_ext};
      `IDX_CAL_START:    next_rdata = {16'h0000, word_cal};
      `IDX_DITHER:       next_rdata = {16'h0000, word_dith};
      `IDX_FIXED_A:      next_rdata = {16'h0000, word_fa};
      `IDX_FIXED_B:      next_rdata = {16'h0000, word_fb};
      `IDX_STATUS:       next_rdata = {16'h0000, status_word};
      default:           next_rhit  = 1'b0;
    endcase
  end

  // One read at a time, data one cycle after the address
  always @(posedge i_clk_sys) begin
    if (i_rst) begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h0000_0000;
      o_rresp   <= `RESP_OKAY;
    end else begin
      if (i_arvalid & o_arready) begin
        o_arready <= 1'b0;
        o_rvalid  <= 1'b1;
        o_rdata   <= next_rdata;
        o_rresp   <= next_rhit ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (o_rvalid & i_rready) begin
        o_rvalid  <= 1'b0;
        o_arready <= 1'b1;
      end
    end
  end

endmodule

// [verif/synth_cfg_checker.sv]
`timescale 1ns/1ps
`include "synth_cfg_regs.vh"

// ----------------------------------------------------------------
// Port checks for the configuration slice
// ----------------------------------------------------------------
module synth_cfg_checker (
  input wire logic        i_clk_sys,           // Clock
  input wire logic        i_rst,               // Sync reset
  input wire logic        i_awvalid,           // AW valid
  input wire logic        o_awready,           // AW ready
  input wire logic        i_wvalid,            // W valid
  input wire logic        o_wready,            // W ready
  input wire logic        o_bvalid,            // B valid
  input wire logic        i_bready,            // B ready
  input wire logic        i_arvalid,           // AR valid
  input wire logic        o_arready,           // AR ready
  input wire logic        o_rvalid,            // R valid
  input wire logic        i_rready,            // R ready
  input wire logic [31:0] o_rdata,             // Read data
  input wire logic [1:0]  i_auto_core,         // Calibration pick
  input wire logic        o_cal_start_force,   // Force flag
  input wire logic [1:0]  o_cal_start_core,    // Start core
  input wire logic        o_high_band_core,    // High band flag
  input wire logic [1:0]  o_dither_level,      // Dither level
  input wire logic [2:0]  o_dither_noise,      // Dither word
  input wire logic [4:0]  o_ext_pump_down,     // Down code
  input wire logic [4:0]  o_ext_pump_up,       // Up code
  input wire logic [5:0]  o_ext_pump_total,    // Sum code
  input wire logic        o_ext_pump_tristate  // Pump off
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  sequence s_wr_taken;
    i_awvalid && o_awready && i_wvalid && o_wready;
  endsequence
  sequence s_rd_taken;
    i_arvalid && o_arready;
  endsequence

  property p_wr_resp;
    s_wr_taken |-> ##1 !o_bvalid ##1 o_bvalid;
  endproperty
  a_wr_resp: assert property (p_wr_resp)
    else $error("write response not two cycles after take");
  property p_rd_resp;
    s_rd_taken |=> o_rvalid && !o_arready;
  endproperty
  a_rd_resp: assert property (p_rd_resp)
    else $error("read data not one cycle after take");
  property p_b_hold;
    o_bvalid && !i_bready |=> o_bvalid;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped while stalled");
  property p_r_hold;
    o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data changed while stalled");
  property p_total;
    o_ext_pump_total == {1'b0, o_ext_pump_down} + {1'b0, o_ext_pump_up};
  endproperty
  a_total: assert property (p_total)
    else $error("pump total is not down plus up");
  property p_tristate;
    o_ext_pump_tristate == (o_ext_pump_down == 5'h00);
  endproperty
  a_tristate: assert property (p_tristate)
    else $error("tristate flag disagrees with down code");
  // Unforced start follows the calibration pick one clock later
  property p_auto;
    !o_cal_start_force && !$past(i_rst) |-> o_cal_start_core == $past(i_auto_core);
  endproperty
  a_auto: assert property (p_auto)
    else $error("unforced start core does not follow calibration");
  property p_high;
    !$past(i_rst) |-> o_high_band_core == (o_cal_start_core == `CORE_HIGH);
  endproperty
  a_high: assert property (p_high)
    else $error("high band flag wrong for start core");
  property p_dither_off;
    o_dither_level == 2'h0 && $past(o_dither_level) == 2'h0 |-> o_dither_noise == 3'h0;
  endproperty
  a_dither_off: assert property (p_dither_off)
    else $error("dither noise present while disabled");
endmodule

// [verif/synth_config_register_slice_bench.sv]
`timescale 1ns/1ps
`include "synth_cfg_regs.vh"

// ----------------------------------------------------------------
// Self-checking bench
// ----------------------------------------------------------------
module synth_config_register_slice_bench;
  logic        i_clk_sys, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
  logic [7:0]  i_awaddr, i_araddr;
  logic [2:0]  i_awprot, i_arprot;
  logic [31:0] i_wdata;
  logic [3:0]  i_wstrb;
  logic [1:0]  i_auto_core;
  wire         o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
  wire  [1:0]  o_bresp, o_rresp, o_cal_start_core, o_dither_level;
  wire  [31:0] o_rdata;
  wire         o_cal_start_force, o_low_band_core, o_mid_band_core, o_high_band_core;
  wire  [2:0]  o_dither_noise;
  wire         o_ext_pump_polarity, o_ext_pump_tristate;
  wire  [4:0]  o_ext_pump_down, o_ext_pump_up;
  wire  [5:0]  o_ext_pump_total;
  wire  [15:0] o_pump_gain_up, o_fixed_a, o_fixed_b;
  int          errors = 0;
  int          check_count = 0;
  int          cyc = 0;
  logic [31:0] rd;
  logic [1:0]  rs;
  logic [5:0]  idx_t [6] = '{`IDX_PUMP_GAIN_UP, `IDX_EXT_PUMP, `IDX_CAL_START,
                             `IDX_DITHER, `IDX_FIXED_A, `IDX_FIXED_B};
  logic [15:0] rst_t [6] = '{`RST_PUMP_GAIN_UP, `RST_EXT_PUMP, `RST_CAL_START,
                             `RST_DITHER, `RST_FIXED_A, `RST_FIXED_B};

  synth_config_register_slice dut_u (.*);

  // Free-running 100 MHz clock
  initial begin
    i_clk_sys = 1'b0;
    forever #5 i_clk_sys = ~i_clk_sys;
  end

  // Hang guard, far above the few hundred cycles needed
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      complete_run;
    end
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic complete_run;
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Write one word; ready to accept the response after stall cycles, at once when stall is 0
  task automatic wr(input logic [5:0] ix, input logic [15:0] d, input logic [3:0] s,
                    input int stall);
    int n;
    @(posedge i_clk_sys);
    n = 0;
    i_awaddr <= {ix, 2'b00};
    i_wdata <= {16'h0000, d};
    i_wstrb <= s;
    i_awvalid <= 1'b1;
    i_wvalid <= 1'b1;
    i_bready <= (stall == 0);
    forever begin
      @(posedge i_clk_sys);
      n++;
      if (i_awvalid && o_awready) i_awvalid <= 1'b0;
      if (i_wvalid && o_wready) i_wvalid <= 1'b0;
      if (i_bready && o_bvalid) break;
      if (n >= stall) i_bready <= 1'b1;
    end
    rs = o_bresp;
    i_bready <= 1'b0;
  endtask

  task automatic rdw(input logic [5:0] ix, input int stall);
    int n;
    @(posedge i_clk_sys);
    n = 0;
    i_araddr <= {ix, 2'b00};
    i_arvalid <= 1'b1;
    i_rready <= (stall == 0);
    forever begin
      @(posedge i_clk_sys);
      n++;
      if (i_arvalid && o_arready) i_arvalid <= 1'b0;
      if (i_rready && o_rvalid) break;
      if (n >= stall) i_rready <= 1'b1;
    end
    rd = o_rdata;
    rs = o_rresp;
    i_rready <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_check_reset;
    for (int i = 0; i < 6; i++) begin
      rdw(idx_t[i], i % 2);
      chk(rd, {16'h0000, rst_t[i]});
    end
    chk(o_ext_pump_total, 6'h20);
    chk(o_ext_pump_tristate, 1'b0);
    chk(o_ext_pump_polarity, 1'b0);
    chk(o_dither_level, 2'h0);
    chk(o_high_band_core, 1'b1);
    chk(o_fixed_b, `RST_FIXED_B);
  endtask

  task automatic t_fixed;
    wr(`IDX_FIXED_B, 16'h8c00, 4'hf, 2);
    chk(rs, `RESP_OKAY);
    wr(`IDX_FIXED_A, 16'h7806, 4'hf, 0);
    rdw(`IDX_FIXED_B, 3);
    chk(rd, 32'h8c00);
    chk(o_fixed_a, 16'h7806);
    chk(o_fixed_b, 16'h8c00);
    // Lane test on the pump word, fixed words stay whole
    wr(`IDX_PUMP_GAIN_UP, 16'h1234, 4'h1, 0);
    rdw(`IDX_PUMP_GAIN_UP, 0);
    chk(rd, 32'h0834);
  endtask

  task automatic t_dither;
    logic [2:0] acc;
    for (int l = 0; l < 4; l++) begin
      wr(`IDX_DITHER, {1'b0, l[1:0], 13'h0000}, 4'h3, 0);
      repeat (2) @(posedge i_clk_sys);
      chk(o_dither_level, l);
      acc = 3'h0;
      repeat (16) begin
        @(posedge i_clk_sys);
        acc = acc | o_dither_noise;
      end
      chk(acc & ~((3'h1 << l) - 3'h1), 3'h0);
      chk(acc != 3'h0, l != 0);
    end
  endtask

  task automatic t_cal;
    i_auto_core <= 2'h1;
    for (int c = 0; c < 3; c++) begin
      wr(`IDX_CAL_START, {13'h0003, 1'b1, c[1:0]}, 4'h3, 0);
      repeat (3) @(posedge i_clk_sys);
      chk(o_cal_start_force, 1'b1);
      chk(o_cal_start_core, c);
      chk({o_high_band_core, o_mid_band_core, o_low_band_core}, 3'h1 << c);
    end
    wr(`IDX_CAL_START, 16'h0018, 4'h3, 0);
    repeat (3) @(posedge i_clk_sys);
    chk(o_cal_start_core, 2'h1);
    chk(o_mid_band_core, 1'b1);
  endtask

  task automatic t_pump;
    logic [4:0] dn [3] = '{5'd0, 5'd30, 5'd2};
    logic [4:0] up [3] = '{5'd0, 5'd30, 5'd2};
    for (int k = 0; k < 3; k++) begin
      wr(`IDX_EXT_PUMP, {10'h008, k[0], dn[k]}, 4'h3, 0);
      wr(`IDX_PUMP_GAIN_UP, {4'h0, up[k], 7'h10}, 4'h3, k);
      repeat (2) @(posedge i_clk_sys);
      chk(o_ext_pump_polarity, k[0]);
      chk(o_ext_pump_down, dn[k]);
      chk(o_ext_pump_tristate, dn[k] == 5'h00);
      chk(o_ext_pump_total, {1'b0, dn[k]} + {1'b0, up[k]});
      chk(o_ext_pump_up, up[k]);
      chk(o_pump_gain_up, {4'h0, up[k], 7'h10});
      rdw(`IDX_PUMP_GAIN_UP, 0);
      chk(rd, {20'h00000, up[k], 7'h10});
    end
  endtask

  task automatic t_errors;
    wr(6'h10, 16'hffff, 4'hf, 0);
    chk(rs, `RESP_SLVERR);
    wr(`IDX_STATUS, 16'hffff, 4'hf, 0);
    chk(rs, `RESP_SLVERR);
    rdw(6'h10, 0);
    chk(rd, 32'h0);
    chk(rs, `RESP_SLVERR);
    // Status: core 1, dither 3, total 4, pump on
    rdw(`IDX_STATUS, 0);
    chk(rd, 32'h004d);
    chk(rs, `RESP_OKAY);
  endtask

  task automatic t_soft;
    i_auto_core <= 2'h2;
    wr(`IDX_CONTROL, 16'h2000, 4'h3, 0);
    chk(rs, `RESP_OKAY);
    t_check_reset;
  endtask

  // Main sequence
  initial begin
    i_rst = 1'b1;
    {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 5'h00;
    i_awaddr = 8'h00;
    i_araddr = 8'h00;
    i_awprot = 3'h0;
    i_arprot = 3'h0;
    i_wdata = 32'h0;
    i_wstrb = 4'h0;
    i_auto_core = 2'h2;
    repeat (6) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    t_check_reset;
    t_fixed;
    t_dither;
    t_cal;
    t_pump;
    t_errors;
    t_soft;
    complete_run;
  end
endmodule

bind synth_config_register_slice synth_cfg_checker chk_u (.*);
